// File: logic/amc_device.sv
// device end: command block interpreter with segment store and profile sequencer
// What this block does
// [RULE1] high word 2000 starts the stored profile
// [RULE2] low bit 9 picks blend or dwell
// [RULE3] low bit 4 gives the run direction
// [RULE4] word 9 is dwell milliseconds, blend ignores it
// [RULE5] unused parameter words are ignored
// [RULE6] high word 4000 presets encoder from words 2,3
// [RULE7] segments stored alike for both profile types
// [RULE8] host opens programming with high word 0800
// [RULE9] first block sets program and request flags
// [RULE10] segment blocks carry high word 1800
// [RULE11] words 2,3 are signed relative target distance
// [RULE12] words 4-7,9 give speed, ramps and jerk
// [RULE13] word 8 is current, even 10 to 60
// [RULE14] bit 12 set latches segment, clears request
// [RULE15] host clears bit 12 once request clears
// [RULE16] bit 12 cleared sets request flag again
// [RULE17] up to sixteen segments are stored
// [RULE18] status bit 8 program ready, bit 9 request
// [RULE19] profile end without error sets move complete
// [RULE20] a new first block discards stored segments
`timescale 1ns/1ns
module amc_device #(
  parameter int unsigned CYC_PER_MS = amc_pkg::CYCLES_PER_MS
) (
  input  wire logic              clock,
  input  wire logic              srst,
  amc_link_if.device             link,
  output logic                   segValid,
  input  wire logic              segDone,
  output logic [31:0]            segTarget,
  output logic [31:0]            segSpeed,
  output logic [15:0]            segAccel,
  output logic [15:0]            segDecel,
  output logic [15:0]            segCurrent,
  output logic                   segCurrentOk,
  output logic [15:0]            segJerk,
  output logic                   runDirCcw,
  output logic                   runDwellMode,
  output logic                   runActive,
  output logic                   encoderLoad,
  output logic [31:0]            encoderValue,
  output logic [4:0]             storedCount
);

  typedef struct packed {
    logic [15:0]                    prevHigh;
    amc_pkg::amc_seg_t [15:0]       store;
    logic [4:0]                     segCount;
    logic                           progFlag;
    logic                           reqFlag;
    logic                           doneFlag;
    amc_pkg::amc_run_t              run;
    logic [4:0]                     runIdx;
    logic                           dwellMode;
    logic                           dirCcw;
    logic [15:0]                    dwellMs;
    logic [15:0]                    msLeft;
    logic [31:0]                    tick;
    amc_pkg::amc_seg_t              cur;
    logic                           encLoad;
    logic [31:0]                    encValue;
  } amc_dev_state_t;

  localparam logic [31:0] TICK_LAST = 32'(CYC_PER_MS - 1);

  amc_dev_state_t   s_q;
  amc_dev_state_t   s_d;
  logic [15:0]      hiWord;
  logic [15:0]      loWord;
  logic             newCmd;
  logic [4:0]       nextIdx;

  assign hiWord  = link.outWords[amc_pkg::WORD_HIGH];
  assign loWord  = link.outWords[amc_pkg::WORD_LOW];
  // a command acts once, on the cycle the high word takes a new value
  assign newCmd  = hiWord != s_q.prevHigh;
  assign nextIdx = s_q.runIdx + 5'h01;

  always_comb begin
    s_d          = s_q;
    s_d.prevHigh = hiWord;
    s_d.encLoad  = 1'b0;

    if (newCmd) begin
      case (hiWord)
        amc_pkg::CMD_RUN_PROFILE: begin
          // ignored while a profile is running; words 2..8 never read here
          if (s_q.run == amc_pkg::AMC_RUN_IDLE) begin // RULE5
            s_d.dwellMode = loWord[amc_pkg::LOW_DWELL_BIT]; // RULE2
            s_d.dirCcw    = loWord[amc_pkg::LOW_DIR_BIT]; // RULE3
            s_d.dwellMs   = loWord[amc_pkg::LOW_DWELL_BIT] ?
                            link.outWords[amc_pkg::WORD_JERK] : 16'h0000; // RULE4
            s_d.progFlag  = 1'b0;
            s_d.reqFlag   = 1'b0;
            s_d.runIdx    = 5'h00;
            s_d.tick      = 32'h0000_0000;
            s_d.doneFlag  = 1'b0;
            if (s_q.segCount == amc_pkg::SEG_COUNT_RESET) begin
              // an empty profile finishes at once
              s_d.doneFlag = 1'b1; // RULE19
            end else begin
              s_d.run = amc_pkg::AMC_RUN_SEG; // RULE1
              s_d.cur = s_q.store[0];
            end
          end
        end
        amc_pkg::CMD_PRESET_ENC: begin
          s_d.encLoad  = 1'b1; // RULE6
          s_d.encValue = {link.outWords[amc_pkg::WORD_POS_UP],
                          link.outWords[amc_pkg::WORD_POS_LO]}; // RULE6
        end
        amc_pkg::CMD_PROG_FIRST: begin
          // 1800 falling to 0800 is the handshake dropping bit 12, not a fresh first block
          if (s_q.prevHigh != amc_pkg::CMD_PROG_SEG) begin
            s_d.segCount = amc_pkg::SEG_COUNT_RESET; // RULE20
            s_d.progFlag = 1'b1; // RULE9
            s_d.reqFlag  = 1'b1; // RULE9
          end
        end
        default: begin
        end
      endcase
    end

    // segment handshake works on the level of bit 12 so a held block is taken once
    if (s_q.progFlag && s_q.reqFlag && hiWord[amc_pkg::HIGH_SEG_BIT]
        && hiWord[amc_pkg::HIGH_PROG_BIT]) begin
      // beyond sixteen the block is dropped but still answered, so the host never hangs
      if (s_q.segCount < amc_pkg::SEG_MAX_COUNT) begin // RULE17
        s_d.store[s_q.segCount[3:0]] = amc_pkg::segFromWords(link.outWords); // RULE7
        s_d.segCount = s_q.segCount + 5'h01; // RULE17
      end
      s_d.reqFlag = 1'b0; // RULE14
    end else if (s_q.progFlag && !s_q.reqFlag && !hiWord[amc_pkg::HIGH_SEG_BIT]) begin
      s_d.reqFlag = 1'b1; // RULE16
    end

    case (s_q.run)
      amc_pkg::AMC_RUN_IDLE: begin
        s_d.tick = 32'h0000_0000;
      end
      amc_pkg::AMC_RUN_SEG: begin
        if (segDone) begin
          if (nextIdx == s_q.segCount) begin
            s_d.run      = amc_pkg::AMC_RUN_IDLE;
            s_d.doneFlag = 1'b1; // RULE19
          end else begin
            s_d.runIdx = nextIdx;
            s_d.cur    = s_q.store[nextIdx[3:0]];
            // blend runs straight on; dwell pauses unless the pause is zero
            if (s_q.dwellMode && (s_q.dwellMs != 16'h0000)) begin // RULE2
              s_d.run    = amc_pkg::AMC_RUN_DWELL;
              s_d.msLeft = s_q.dwellMs; // RULE4
              s_d.tick   = 32'h0000_0000;
            end
          end
        end
      end
      amc_pkg::AMC_RUN_DWELL: begin
        if (s_q.tick == TICK_LAST) begin
          s_d.tick   = 32'h0000_0000;
          s_d.msLeft = s_q.msLeft - 16'h0001; // RULE4
          if (s_q.msLeft == 16'h0001) begin
            s_d.run = amc_pkg::AMC_RUN_SEG;
          end
        end else begin
          s_d.tick = s_q.tick + 32'h0000_0001;
        end
      end
      default: begin
        s_d.run = amc_pkg::AMC_RUN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q           <= '0;
      s_q.run       <= amc_pkg::AMC_RUN_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    link.statusWord1                                = 16'h0000;
    link.statusWord1[amc_pkg::ST_PROGRAM_BIT]       = s_q.progFlag; // RULE18
    link.statusWord1[amc_pkg::ST_SEGREQ_BIT]        = s_q.reqFlag; // RULE18
    link.statusWord1[amc_pkg::ST_COMPLETE_BIT]      = s_q.doneFlag; // RULE19
    link.statusWord1[amc_pkg::ST_STOPPED_BIT]       = s_q.run != amc_pkg::AMC_RUN_SEG;
    link.statusWord1[amc_pkg::ST_CW_BIT]            = (s_q.run == amc_pkg::AMC_RUN_SEG)
                                                      && !s_q.dirCcw;
    link.statusWord1[amc_pkg::ST_CCW_BIT]           = (s_q.run == amc_pkg::AMC_RUN_SEG)
                                                      && s_q.dirCcw;
  end

  // the motion generator sees only what the current segment carries
  assign segValid     = s_q.run == amc_pkg::AMC_RUN_SEG;
  assign segTarget    = s_q.cur.target; // RULE11
  assign segSpeed     = s_q.cur.speed; // RULE12
  assign segAccel     = s_q.cur.accel; // RULE12
  assign segDecel     = s_q.cur.decel; // RULE12
  assign segJerk      = s_q.cur.jerk; // RULE12
  assign segCurrent   = s_q.cur.current;
  // an out-of-range current is flagged, never a command error
  assign segCurrentOk = amc_pkg::currentOk(s_q.cur.current); // RULE13
  assign runDirCcw    = s_q.dirCcw;
  assign runDwellMode = s_q.dwellMode;
  assign runActive    = s_q.run != amc_pkg::AMC_RUN_IDLE;
  assign encoderLoad  = s_q.encLoad;
  assign encoderValue = s_q.encValue;
  assign storedCount  = s_q.segCount;

endmodule

// File: pkg/amc_pkg.sv
// constants, types and decode helpers shared by both ends of the move command link
package amc_pkg;

  // word positions inside the ten-word output block
  localparam int unsigned WORD_HIGH     = 0;
  localparam int unsigned WORD_LOW      = 1;
  localparam int unsigned WORD_POS_UP   = 2;
  localparam int unsigned WORD_POS_LO   = 3;
  localparam int unsigned WORD_SPD_UP   = 4;
  localparam int unsigned WORD_SPD_LO   = 5;
  localparam int unsigned WORD_ACCEL    = 6;
  localparam int unsigned WORD_DECEL    = 7;
  localparam int unsigned WORD_CURRENT  = 8;
  localparam int unsigned WORD_JERK     = 9;
  localparam int unsigned WORD_COUNT    = 10;

  // register numbers of the output block on the network
  localparam logic [15:0] REG_COMMAND_WORD_HIGH  = 16'h0400;
  localparam logic [15:0] REG_COMMAND_WORD_LOW   = 16'h0401;
  localparam logic [15:0] REG_PARAMETER_WORD_2   = 16'h0402;
  localparam logic [15:0] REG_PARAMETER_WORD_3   = 16'h0403;
  localparam logic [15:0] REG_SPEED_UPPER_WORD   = 16'h0404;
  localparam logic [15:0] REG_SPEED_LOWER_WORD   = 16'h0405;
  localparam logic [15:0] REG_ACCELERATION_WORD  = 16'h0406;
  localparam logic [15:0] REG_DECELERATION_WORD  = 16'h0407;
  localparam logic [15:0] REG_MOTOR_CURRENT_WORD = 16'h0408;
  localparam logic [15:0] REG_JERK_OR_DWELL_WORD = 16'h0409;

  // command codes of the high command word
  localparam logic [15:0] CMD_NONE        = 16'h0000;
  localparam logic [15:0] CMD_RUN_PROFILE = 16'h2000;
  localparam logic [15:0] CMD_PRESET_ENC  = 16'h4000;
  localparam logic [15:0] CMD_PROG_FIRST  = 16'h0800;
  localparam logic [15:0] CMD_PROG_SEG    = 16'h1800;

  // bit positions
  localparam int unsigned HIGH_SEG_BIT    = 12;
  localparam int unsigned HIGH_PROG_BIT   = 11;
  localparam int unsigned LOW_DWELL_BIT   = 9;
  localparam int unsigned LOW_DIR_BIT     = 4;
  localparam int unsigned ST_CW_BIT       = 0;
  localparam int unsigned ST_CCW_BIT      = 1;
  localparam int unsigned ST_STOPPED_BIT  = 3;
  localparam int unsigned ST_COMPLETE_BIT = 7;
  localparam int unsigned ST_PROGRAM_BIT  = 8;
  localparam int unsigned ST_SEGREQ_BIT   = 9;

  // segment storage
  localparam int unsigned SEG_MAX         = 16;
  localparam logic [4:0]  SEG_MAX_COUNT   = 5'h10;
  localparam logic [4:0]  SEG_COUNT_RESET = 5'h00;

  // motor current limits in tenths of an ampere
  localparam logic [15:0] CURRENT_MIN     = 16'h000A;
  localparam logic [15:0] CURRENT_MAX     = 16'h003C;

  // dwell timebase
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned DWELL_UNIT_NS   = 1000000;
  localparam int unsigned CYCLES_PER_MS   = DWELL_UNIT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [31:0] target;
    logic [31:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] current;
    logic [15:0] jerk;
  } amc_seg_t;

  typedef enum logic [1:0] {
    AMC_RUN_IDLE  = 2'b00,
    AMC_RUN_SEG   = 2'b01,
    AMC_RUN_DWELL = 2'b11
  } amc_run_t;

  typedef enum logic [2:0] {
    AMC_HOST_IDLE  = 3'b000,
    AMC_HOST_CLEAR = 3'b001,
    AMC_HOST_FIRST = 3'b011,
    AMC_HOST_SEGW  = 3'b010,
    AMC_HOST_SEGR  = 3'b110
  } amc_host_t;

  typedef enum logic [1:0] {
    AMC_KIND_RUN     = 2'b00,
    AMC_KIND_PRESET  = 2'b01,
    AMC_KIND_PROGRAM = 2'b10,
    AMC_KIND_SEGMENT = 2'b11
  } amc_kind_t;

  // motor current is usable only when even and inside the limits
  function automatic logic currentOk(input logic [15:0] cur);
    currentOk = !cur[0] && (cur >= CURRENT_MIN) && (cur <= CURRENT_MAX);
  endfunction

  // unpack parameter words 2..9 of a block into a segment
  function automatic amc_seg_t segFromWords(input logic [9:0][15:0] w);
    segFromWords.target  = {w[WORD_POS_UP], w[WORD_POS_LO]};
    segFromWords.speed   = {w[WORD_SPD_UP], w[WORD_SPD_LO]};
    segFromWords.accel   = w[WORD_ACCEL];
    segFromWords.decel   = w[WORD_DECEL];
    segFromWords.current = w[WORD_CURRENT];
    segFromWords.jerk    = w[WORD_JERK];
  endfunction

endpackage

// File: pkg/amc_link_if.sv
// network link between host and device: ten output words and the first status word
`timescale 1ns/1ns
interface amc_link_if;
  logic [9:0][15:0] outWords;
  logic [15:0]      statusWord1;

  modport device (
    input  outWords,
    output statusWord1
  );

  modport host (
    output outWords,
    input  statusWord1
  );
endinterface

// File: logic/amc_host.sv
// host end: turns user commands into command blocks and drives the segment handshake
`timescale 1ns/1ns
module amc_host (
  input  wire logic              clock,
  input  wire logic              srst,
  amc_link_if.host               link,
  input  wire logic              cmdValid,
  output logic                   cmdReady,
  input  wire amc_pkg::amc_kind_t cmdKind,
  input  wire logic [15:0]       cmdLow,
  input  wire logic [7:0][15:0]  cmdParams,
  output logic                   progReady,
  output logic                   moveComplete
);

  typedef struct packed {
    amc_pkg::amc_host_t   st;
    logic [9:0][15:0]     words;
    amc_pkg::amc_kind_t   kind;
  } amc_host_state_t;

  amc_host_state_t  s_q;
  amc_host_state_t  s_d;
  logic             flagProg;
  logic             flagReq;
  logic             take;
  logic [15:0]      code;

  assign flagProg = link.statusWord1[amc_pkg::ST_PROGRAM_BIT];
  assign flagReq  = link.statusWord1[amc_pkg::ST_SEGREQ_BIT];
  // segments wait for both flags, other commands only for an idle host
  assign cmdReady = (s_q.st == amc_pkg::AMC_HOST_IDLE) &&
                    ((cmdKind != amc_pkg::AMC_KIND_SEGMENT) || (flagProg && flagReq)); // RULE9
  assign take     = cmdValid && cmdReady;

  always_comb begin
    case (s_q.kind)
      amc_pkg::AMC_KIND_RUN:     code = amc_pkg::CMD_RUN_PROFILE; // RULE1
      amc_pkg::AMC_KIND_PRESET:  code = amc_pkg::CMD_PRESET_ENC; // RULE6
      amc_pkg::AMC_KIND_PROGRAM: code = amc_pkg::CMD_PROG_FIRST; // RULE8
      default:                   code = amc_pkg::CMD_NONE;
    endcase
  end

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      amc_pkg::AMC_HOST_IDLE: begin
        if (take) begin
          s_d.kind     = cmdKind;
          s_d.words[1] = cmdLow;
          s_d.words[9:2] = cmdParams;
          if (cmdKind == amc_pkg::AMC_KIND_SEGMENT) begin
            s_d.words[0] = amc_pkg::CMD_PROG_SEG; // RULE10
            s_d.st       = amc_pkg::AMC_HOST_SEGW;
          end else begin
            // a zero word first, so a repeated command is still a new value
            s_d.words[0] = amc_pkg::CMD_NONE;
            s_d.st       = amc_pkg::AMC_HOST_CLEAR;
          end
        end
      end
      amc_pkg::AMC_HOST_CLEAR: begin
        s_d.words[0] = code;
        s_d.st       = (s_q.kind == amc_pkg::AMC_KIND_PROGRAM) ?
                       amc_pkg::AMC_HOST_FIRST : amc_pkg::AMC_HOST_IDLE;
      end
      amc_pkg::AMC_HOST_FIRST: begin
        if (flagProg && flagReq) begin
          s_d.st = amc_pkg::AMC_HOST_IDLE; // RULE9
        end
      end
      amc_pkg::AMC_HOST_SEGW: begin
        if (!flagReq) begin
          s_d.words[0] = amc_pkg::CMD_PROG_FIRST; // RULE15
          s_d.st       = amc_pkg::AMC_HOST_SEGR;
        end
      end
      amc_pkg::AMC_HOST_SEGR: begin
        if (flagReq) begin
          s_d.st = amc_pkg::AMC_HOST_IDLE; // RULE16
        end
      end
      default: begin
        s_d.st = amc_pkg::AMC_HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q    <= '0;
      s_q.st <= amc_pkg::AMC_HOST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.outWords = s_q.words;
  assign progReady     = flagProg && flagReq;
  assign moveComplete  = link.statusWord1[amc_pkg::ST_COMPLETE_BIT];

endmodule

// File: verif/amc_link_assertions.sv
// concurrent checks on the link between host and device ends
`timescale 1ns/1ns
module amc_link_assertions (
  input wire logic             clock,
  input wire logic             srst,
  input wire logic [9:0][15:0] outWords,
  input wire logic [15:0]      statusWord1
);
  logic [15:0] high;
  assign high = outWords[0];

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_reset_status: assert property ($fell(srst) |-> statusWord1 == 16'h0008)
    else $error("status word not idle after reset");
  a_first_flags: assert property ($changed(high) && high == amc_pkg::CMD_PROG_FIRST
    |=> statusWord1[9:8] == 2'b11) else $error("first block did not raise both flags");
  a_seg_clears_req: assert property (statusWord1[9:8] == 2'b11 && high[12] && high[11]
    |=> !statusWord1[9]) else $error("segment block did not clear request flag");
  a_req_rise_cause: assert property ($rose(statusWord1[9])
    |-> $past(high) == amc_pkg::CMD_PROG_FIRST) else $error("request flag rose early");
  a_host_clears_seg: assert property ($fell(statusWord1[9]) && statusWord1[8]
    |=> !high[12]) else $error("host kept bit 12 after request cleared");
  a_req_fall_cause: assert property ($fell(statusWord1[9]) && statusWord1[8]
    |-> $past(high[12])) else $error("request flag fell with no segment");
  a_prog_rise_cause: assert property ($rose(statusWord1[8])
    |-> $past(high) == amc_pkg::CMD_PROG_FIRST) else $error("program flag rose uncommanded");
  a_run_leaves_prog: assert property ($changed(high) && high == amc_pkg::CMD_RUN_PROFILE
    |=> statusWord1[9:8] == 2'b00) else $error("run start kept programming flags");
  a_done_clear_cause: assert property ($fell(statusWord1[7])
    |-> $past(high) == amc_pkg::CMD_RUN_PROFILE) else $error("move complete dropped oddly");
  a_one_direction: assert property (!(statusWord1[0] && statusWord1[1]))
    else $error("both directions reported");

  cover property ($rose(statusWord1[7]));
  cover property (high == amc_pkg::CMD_PROG_SEG && statusWord1[9]);
  cover property ($changed(high) && high == amc_pkg::CMD_PRESET_ENC);
endmodule

// File: verif/assembled_move_command_blocks_test.sv
// self-checking bench joining host and device ends over the link
`timescale 1ns/1ns
module assembled_move_command_blocks_test;
  logic               clock, srst, cmdValid, cmdReady, progReady, moveComplete;
  logic               segValid, segDone, segCurrentOk, runDirCcw, runDwellMode;
  logic               runActive, encoderLoad;
  amc_pkg::amc_kind_t cmdKind;
  logic [15:0]        cmdLow, segAccel, segDecel, segCurrent, segJerk;
  logic [7:0][15:0]   cmdParams;
  logic [31:0]        segTarget, segSpeed, encoderValue;
  logic [4:0]         storedCount;
  int                 fail_count, samples_checked, cycles;

  amc_link_if link();
  amc_host u_amc_host (.clock(clock), .srst(srst), .link(link.host), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdLow(cmdLow), .cmdParams(cmdParams),
    .progReady(progReady), .moveComplete(moveComplete));
  // dwell timebase shortened so a millisecond is four cycles
  amc_device #(.CYC_PER_MS(4)) u_amc_device (.clock(clock), .srst(srst), .link(link.device),
    .segValid(segValid), .segDone(segDone), .segTarget(segTarget), .segSpeed(segSpeed),
    .segAccel(segAccel), .segDecel(segDecel), .segCurrent(segCurrent),
    .segCurrentOk(segCurrentOk), .segJerk(segJerk), .runDirCcw(runDirCcw),
    .runDwellMode(runDwellMode), .runActive(runActive), .encoderLoad(encoderLoad),
    .encoderValue(encoderValue), .storedCount(storedCount));
  amc_link_assertions u_amc_link_assertions (.clock(clock), .srst(srst),
    .outWords(link.outWords), .statusWord1(link.statusWord1));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under this many cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // segment two carries an odd current so the validity flag must drop
  function automatic logic [7:0][15:0] segp(input int i);
    segp[0] = (i == 1) ? 16'hFFFF : 16'h0000;
    segp[1] = 16'h0100 + 16'(i);
    segp[2] = 16'h0002;
    segp[3] = 16'h0010 + 16'(i);
    segp[4] = 16'h0064;
    segp[5] = 16'h0032;
    segp[6] = (i == 2) ? 16'h000B : 16'h000C;
    segp[7] = 16'h0005;
  endfunction

  task automatic issue(input amc_pkg::amc_kind_t k, input logic [15:0] low,
                       input logic [7:0][15:0] p);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdKind <= k;
    cmdLow <= low;
    cmdParams <= p;
    do @(negedge clock); while (cmdReady !== 1'b1);
    @(posedge clock);
    cmdValid <= 1'b0;
  endtask

  task automatic prog(input int n);
    int exp;
    exp = (n > 16) ? 16 : n;
    issue(amc_pkg::AMC_KIND_PROGRAM, 16'hFFFF, {8{16'hFFFF}});
    do @(negedge clock); while (progReady !== 1'b1);
    for (int i = 0; i < n; i++) begin
      issue(amc_pkg::AMC_KIND_SEGMENT, 16'h0000, segp(i));
    end
    do @(negedge clock); while (cmdReady !== 1'b1);
    check("storedCount", 32'(storedCount), 32'(exp));
    check("progReady", 32'(progReady), 32'h0000_0001);
    $display("program %0d segments done", n);
  endtask

  task automatic run(input logic dwell, input logic ccw, input logic [15:0] ms, input int n);
    logic [7:0][15:0] p;
    int gap;
    p = {8{16'hA5A5}};
    p[7] = ms;
    issue(amc_pkg::AMC_KIND_RUN, (16'(dwell) << 9) | (16'(ccw) << 4), p);
    do @(negedge clock); while (segValid !== 1'b1);
    check("moveComplete start", 32'(moveComplete), 32'h0000_0000);
    check("runDwellMode", 32'(runDwellMode), 32'(dwell));
    check("runDirCcw", 32'(runDirCcw), 32'(ccw));
    check("direction bits", 32'(link.statusWord1[1:0]), {30'h0, ccw, !ccw});
    check("runActive start", 32'(runActive), 32'h0000_0001);
    for (int i = 0; i < n; i++) begin
      p = segp(i);
      check("segTarget", segTarget, {p[0], p[1]});
      check("segSpeed", segSpeed, {p[2], p[3]});
      check("segAccel", 32'(segAccel), 32'(p[4]));
      check("segDecel", 32'(segDecel), 32'(p[5]));
      check("segCurrent", 32'(segCurrent), 32'(p[6]));
      check("segJerk", 32'(segJerk), 32'(p[7]));
      check("segCurrentOk", 32'(segCurrentOk), 32'(i != 2));
      @(posedge clock);
      segDone <= 1'b1;
      @(posedge clock);
      segDone <= 1'b0;
      @(negedge clock);
      if (i < n - 1) begin
        // a dwell leaves a gap, a blend moves straight on
        check("segValid next", 32'(segValid), 32'(!dwell));
        gap = 0;
        while (segValid !== 1'b1) begin
          @(negedge clock);
          gap++;
        end
        // four cycles per millisecond in this bench; a blend leaves no gap at all
        check("dwell length", 32'(gap), dwell ? 32'(4 * ms) : 32'h0000_0000);
      end
    end
    check("segValid end", 32'(segValid), 32'h0000_0000);
    check("runActive end", 32'(runActive), 32'h0000_0000);
    check("moveComplete end", 32'(moveComplete), 32'h0000_0001);
    $display("run of %0d segments done", n);
  endtask

  task automatic preset();
    logic [7:0][15:0] p;
    p = {8{16'h5A5A}};
    p[0] = 16'h8001;
    p[1] = 16'h1234;
    issue(amc_pkg::AMC_KIND_PRESET, 16'h0000, p);
    for (int k = 0; k < 10 && encoderLoad !== 1'b1; k++) @(negedge clock);
    check("encoderLoad", 32'(encoderLoad), 32'h0000_0001);
    check("encoderValue", encoderValue, 32'h8001_1234);
    @(negedge clock);
    check("encoderLoad pulse", 32'(encoderLoad), 32'h0000_0000);
    $display("preset done");
  endtask

  initial begin
    srst = 1'b1;
    cmdValid = 1'b0;
    cmdKind = amc_pkg::AMC_KIND_RUN;
    cmdLow = 16'h0000;
    cmdParams = '0;
    segDone = 1'b0;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    prog(3);
    run(1'b0, 1'b1, 16'h0007, 3);
    run(1'b1, 1'b0, 16'h0002, 3);
    preset();
    prog(17);
    prog(1);
    run(1'b0, 1'b0, 16'h0000, 1);
    finish_test();
  end
endmodule
